// ### rtl/lecl_consts.svh
// widths, masks and reset values for the ladder edge and compare logic
`ifndef LECL_CONSTS_SVH
`define LECL_CONSTS_SVH

`define LECL_WORD_W   16
`define LECL_DWORD_W  32
`define LECL_OP_W     3
`define LECL_MASK16   16'hFFFF
`define LECL_MASK32   32'hFFFF_FFFF
`define LECL_RST_BIT  1'h0
`define LECL_RST_W16  16'h0000
`define LECL_RST_W32  32'h0000_0000

`endif

// ### rtl/lecl_pkg.sv
// types shared by the ladder edge and compare logic
`include "lecl_consts.svh"

package lecl_pkg;

	// relation chosen for the compare contact
	typedef enum logic [`LECL_OP_W-1:0] {
		LECL_REL_EQ,
		LECL_REL_NE,
		LECL_REL_GT,
		LECL_REL_LT,
		LECL_REL_GE,
		LECL_REL_LE
	} lecl_rel_e;

	// whole state of the block
	typedef struct packed {
		logic                     rfall_mem;
		logic                     rfall_q;
		logic                     rrise_mem;
		logic                     rrise_q;
		logic                     pos_mem;
		logic                     pos_q;
		logic                     neg_mem;
		logic                     neg_q;
		logic                     cmp_q;
		logic [`LECL_WORD_W-1:0]  inv16;
		logic [`LECL_DWORD_W-1:0] inv32;
		logic [`LECL_WORD_W-1:0]  and16;
	} lecl_state_s;

endpackage

// ### rtl/lecl_top.sv
// scan-evaluated edge detectors, compare contact, inverters and word AND
`timescale 1ns/10ps
`include "lecl_consts.svh"

// Behaviour
// - result-falling edge: memory 1, input 0
// - result-falling edge stores input every evaluation
// - bit rising: result 1, bit 1, memory 0
// - bit falling: result 1, bit 0, memory 1
// - bit detectors keep previous-scan bit value
// - compare takes 16 or 32-bit signed operands
// - six relations: eq ne gt lt ge le
// - compare result 1 when relation holds
// - 16-bit inverter XORs with all ones
// - 32-bit inverter XORs with all ones
// - enable output always equals enable input
// - results held, updated on phase while enabled
// - word AND of two 16-bit patterns
// - result-rising edge: memory 0, input 1
module lecl_top
(
	// clock and reset
	input  wire logic                     ref_clk_i,
	input  wire logic                     sys_rst_i,
	// evaluation strobes
	input  wire logic                     scan_i,
	input  wire logic                     phase_i,
	// falling edge on the logic result
	input  wire logic                     rfall_lr_i,
	output logic                          rfall_lr_o,
	// rising edge on the logic result
	input  wire logic                     rrise_lr_i,
	output logic                          rrise_lr_o,
	// rising edge on a scanned bit
	input  wire logic                     pos_lr_i,
	input  wire logic                     pos_bit_i,
	output logic                          pos_q_o,
	output logic                          pos_lr_o,
	// falling edge on a scanned bit
	input  wire logic                     neg_lr_i,
	input  wire logic                     neg_bit_i,
	output logic                          neg_q_o,
	output logic                          neg_lr_o,
	// relational compare contact
	input  wire logic                     cmp_wide_i,
	input  wire logic [`LECL_OP_W-1:0]    cmp_rel_i,
	input  wire logic [`LECL_DWORD_W-1:0] cmp_first_operand_i,
	input  wire logic [`LECL_DWORD_W-1:0] cmp_second_operand_i,
	output logic                          cmp_lr_o,
	// 16-bit inverter
	input  wire logic                     inv16_en_i,
	input  wire logic [`LECL_WORD_W-1:0]  inv16_in_i,
	output logic                          inv16_enable_output_o,
	output logic [`LECL_WORD_W-1:0]       inv16_out_o,
	// 32-bit inverter
	input  wire logic                     inv32_en_i,
	input  wire logic [`LECL_DWORD_W-1:0] inv32_in_i,
	output logic                          inv32_enable_output_o,
	output logic [`LECL_DWORD_W-1:0]      inv32_out_o,
	// 16-bit word AND
	input  wire logic                     and_en_i,
	input  wire logic [`LECL_WORD_W-1:0]  and_first_operand_i,
	input  wire logic [`LECL_WORD_W-1:0]  and_second_operand_i,
	output logic                          and_enable_output_o,
	output logic [`LECL_WORD_W-1:0]       and_out_o
);

	// =====================================================
	// operand shaping
	// =====================================================
	// narrow operands are sign-extended so one 32-bit compare serves both
	logic signed [`LECL_DWORD_W-1:0] op_a;
	logic signed [`LECL_DWORD_W-1:0] op_b;
	logic                            rel_hit;
	lecl_pkg::lecl_rel_e             rel;
	lecl_pkg::lecl_state_s           st_r;
	lecl_pkg::lecl_state_s           st_nxt;

	always_comb
	begin
		if (cmp_wide_i)
		begin
			op_a = cmp_first_operand_i;
			op_b = cmp_second_operand_i;
		end
		else
		begin
			op_a = {{`LECL_WORD_W{cmp_first_operand_i[`LECL_WORD_W-1]}},
				cmp_first_operand_i[`LECL_WORD_W-1:0]};
			op_b = {{`LECL_WORD_W{cmp_second_operand_i[`LECL_WORD_W-1]}},
				cmp_second_operand_i[`LECL_WORD_W-1:0]};
		end
	end

	// =====================================================
	// relation select
	// =====================================================
	always_comb
	begin
		rel = lecl_pkg::lecl_rel_e'(cmp_rel_i);
		case (rel)
			lecl_pkg::LECL_REL_EQ: rel_hit = (op_a == op_b);
			lecl_pkg::LECL_REL_NE: rel_hit = (op_a != op_b);
			lecl_pkg::LECL_REL_GT: rel_hit = (op_a >  op_b);
			lecl_pkg::LECL_REL_LT: rel_hit = (op_a <  op_b);
			lecl_pkg::LECL_REL_GE: rel_hit = (op_a >= op_b);
			lecl_pkg::LECL_REL_LE: rel_hit = (op_a <= op_b);
			// unused codes never close the contact
			default:               rel_hit = 1'h0;
		endcase
	end

	// =====================================================
	// next state
	// =====================================================
	always_comb
	begin
		st_nxt = st_r;
		if (scan_i)
		begin
			st_nxt.rfall_q   = st_r.rfall_mem & ~rfall_lr_i;
			st_nxt.rfall_mem = rfall_lr_i;
			st_nxt.rrise_q   = ~st_r.rrise_mem & rrise_lr_i;
			st_nxt.rrise_mem = rrise_lr_i;
			st_nxt.pos_q     = pos_lr_i & pos_bit_i & ~st_r.pos_mem;
			st_nxt.pos_mem   = pos_bit_i;
			st_nxt.neg_q     = neg_lr_i & ~neg_bit_i & st_r.neg_mem;
			st_nxt.neg_mem   = neg_bit_i;
			st_nxt.cmp_q     = rel_hit;
		end
		// storage follows the phase clock only while enabled
		if (phase_i && inv16_en_i)
			st_nxt.inv16 = inv16_in_i ^ `LECL_MASK16;
		if (phase_i && inv32_en_i)
			st_nxt.inv32 = inv32_in_i ^ `LECL_MASK32;
		if (phase_i && and_en_i)
			st_nxt.and16 = and_first_operand_i & and_second_operand_i;
	end

	// =====================================================
	// state register
	// =====================================================
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			st_r.rfall_mem <= `LECL_RST_BIT;
			st_r.rfall_q   <= `LECL_RST_BIT;
			st_r.rrise_mem <= `LECL_RST_BIT;
			st_r.rrise_q   <= `LECL_RST_BIT;
			st_r.pos_mem   <= `LECL_RST_BIT;
			st_r.pos_q     <= `LECL_RST_BIT;
			st_r.neg_mem   <= `LECL_RST_BIT;
			st_r.neg_q     <= `LECL_RST_BIT;
			st_r.cmp_q     <= `LECL_RST_BIT;
			st_r.inv16     <= `LECL_RST_W16;
			st_r.inv32     <= `LECL_RST_W32;
			st_r.and16     <= `LECL_RST_W16;
		end
		else
			st_r <= st_nxt;
	end

	// =====================================================
	// outputs
	// =====================================================
	assign rfall_lr_o = st_r.rfall_q;
	assign rrise_lr_o = st_r.rrise_q;
	assign pos_q_o    = st_r.pos_q;
	assign pos_lr_o   = st_r.pos_q;
	assign neg_q_o    = st_r.neg_q;
	assign neg_lr_o   = st_r.neg_q;
	assign cmp_lr_o   = st_r.cmp_q;
	assign inv16_out_o = st_r.inv16;
	assign inv32_out_o = st_r.inv32;
	assign and_out_o   = st_r.and16;
	// enables pass straight through, never delayed
	assign inv16_enable_output_o = inv16_en_i;
	assign inv32_enable_output_o = inv32_en_i;
	assign and_enable_output_o   = and_en_i;

	// =====================================================
	// checks
	// =====================================================
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_pos_fire;
		scan_i && pos_lr_i && pos_bit_i && !st_r.pos_mem;
	endsequence

	sequence s_neg_fire;
		scan_i && neg_lr_i && !neg_bit_i && st_r.neg_mem;
	endsequence

	sequence s_and_load;
		phase_i && and_en_i;
	endsequence

	// no evaluation this cycle: edge detectors must hold everything
	sequence s_no_scan;
		!scan_i;
	endsequence

	AST_RFALL_OUT: assert property (
		scan_i |=> rfall_lr_o == ($past(st_r.rfall_mem) && !$past(rfall_lr_i)))
		else $error("result falling edge output wrong");

	AST_RFALL_MEM: assert property (
		scan_i ##1 (scan_i && !rfall_lr_i) |=> rfall_lr_o == $past(rfall_lr_i, 2))
		else $error("result falling edge memory not updated");

	AST_RRISE_FIRE: assert property (
		scan_i && rrise_lr_i && !st_r.rrise_mem |=> rrise_lr_o)
		else $error("result rising edge missed");

	AST_RRISE_OUT: assert property (
		scan_i && rrise_lr_i ##1 scan_i |=> !rrise_lr_o)
		else $error("result rising edge fired twice");

	AST_POS_FIRE: assert property (
		s_pos_fire |=> pos_q_o && pos_lr_o)
		else $error("bit rising edge missed");

	AST_NEG_FIRE: assert property (
		s_neg_fire |=> neg_q_o && neg_lr_o)
		else $error("bit falling edge missed");

	AST_POS_QUIET: assert property (
		scan_i && !(pos_lr_i && pos_bit_i && !st_r.pos_mem) |=> !pos_q_o)
		else $error("bit rising edge fired without cause");

	AST_NEG_QUIET: assert property (
		scan_i && !(neg_lr_i && !neg_bit_i && st_r.neg_mem) |=> !neg_q_o)
		else $error("bit falling edge fired without cause");

	AST_LR_SAME: assert property (
		pos_lr_o == pos_q_o && neg_lr_o == neg_q_o)
		else $error("one-shot and logic result differ");

	AST_SCAN_HOLD: assert property (
		s_no_scan |=> $stable(st_r.pos_mem) && $stable(st_r.neg_mem)
			&& $stable(pos_q_o) && $stable(neg_q_o))
		else $error("edge detector changed without a scan");

	AST_EDGE_MEM: assert property (
		scan_i && pos_bit_i ##1 scan_i && pos_lr_i |=> !pos_q_o)
		else $error("bit rising edge memory not kept");

	AST_NEG_MEM: assert property (
		scan_i && !neg_bit_i ##1 scan_i && neg_lr_i |=> !neg_q_o)
		else $error("bit falling edge memory not kept");

	AST_CMP_EQ: assert property (
		scan_i && cmp_rel_i == lecl_pkg::LECL_REL_EQ
		&& (cmp_wide_i ? cmp_first_operand_i == cmp_second_operand_i
		: cmp_first_operand_i[15:0] == cmp_second_operand_i[15:0])
		|=> cmp_lr_o)
		else $error("equal compare not closed");

	AST_CMP_NE32: assert property (
		scan_i && cmp_wide_i && cmp_rel_i == lecl_pkg::LECL_REL_NE
		&& cmp_first_operand_i == cmp_second_operand_i |=> !cmp_lr_o)
		else $error("wide not-equal closed wrongly");

	AST_CMP_GT16: assert property (
		scan_i && !cmp_wide_i && cmp_rel_i == lecl_pkg::LECL_REL_GT
		&& $signed(cmp_first_operand_i[15:0]) > $signed(cmp_second_operand_i[15:0])
		|=> cmp_lr_o)
		else $error("narrow signed greater failed");

	AST_CMP_BAD: assert property (
		scan_i && cmp_rel_i > lecl_pkg::LECL_REL_LE |=> !cmp_lr_o)
		else $error("unused relation closed the contact");

	AST_CMP_LT16: assert property (
		scan_i && !cmp_wide_i && cmp_rel_i == lecl_pkg::LECL_REL_LT
		&& $signed(cmp_first_operand_i[15:0]) < $signed(cmp_second_operand_i[15:0])
		|=> cmp_lr_o)
		else $error("narrow signed less-than failed");

	AST_CMP_GE32: assert property (
		scan_i && cmp_wide_i && cmp_rel_i == lecl_pkg::LECL_REL_GE
		&& $signed(cmp_first_operand_i) < $signed(cmp_second_operand_i)
		|=> !cmp_lr_o)
		else $error("wide greater-or-equal closed wrongly");

	AST_INV16: assert property (
		phase_i && inv16_en_i |=> (inv16_out_o ^ $past(inv16_in_i)) == `LECL_MASK16)
		else $error("16-bit inverter result wrong");

	AST_INV32: assert property (
		phase_i && inv32_en_i |=> (inv32_out_o ^ $past(inv32_in_i)) == `LECL_MASK32)
		else $error("32-bit inverter result wrong");

	AST_ENO: assert property (
		and_enable_output_o == and_en_i && inv16_enable_output_o == inv16_en_i
		&& inv32_enable_output_o == inv32_en_i)
		else $error("enable output differs from enable");

	AST_HOLD: assert property (
		!(phase_i && and_en_i) && !(phase_i && inv16_en_i)
		|=> $stable(and_out_o) && $stable(inv16_out_o))
		else $error("stored result changed while disabled");

	AST_HOLD32: assert property (
		!(phase_i && inv32_en_i) |=> $stable(inv32_out_o))
		else $error("stored 32-bit result changed while disabled");

	AST_AND: assert property (
		s_and_load |=> and_out_o == ($past(and_first_operand_i)
			& $past(and_second_operand_i)))
		else $error("word AND result wrong");

endmodule // lecl_top

// ### verif/test_ladder_edge_compare_logic.sv
// self-checking testbench for the ladder edge and compare logic
`timescale 1ns/10ps
module test_ladder_edge_compare_logic;
	// ==========================================
	// stimulus and observed signals
	logic        ref_clk_i = 1'h0, sys_rst_i = 1'h1, scan_i = 1'h0, phase_i = 1'h0;
	logic        rfall_lr_i = 1'h0, rrise_lr_i = 1'h0, rfall_lr_o, rrise_lr_o;
	logic        pos_lr_i = 1'h0, pos_bit_i = 1'h0, pos_q_o, pos_lr_o;
	logic        neg_lr_i = 1'h0, neg_bit_i = 1'h0, neg_q_o, neg_lr_o;
	logic        cmp_wide_i = 1'h0, cmp_lr_o;
	logic [2:0]  cmp_rel_i = 3'h0;
	logic [31:0] cmp_first_operand_i = 32'h0, cmp_second_operand_i = 32'h0;
	logic        inv16_en_i = 1'h0, inv32_en_i = 1'h0, and_en_i = 1'h0;
	logic [15:0] inv16_in_i = 16'h0, and_first_operand_i = 16'h0, and_second_operand_i = 16'h0;
	logic [31:0] inv32_in_i = 32'h0, inv32_out_o;
	logic [15:0] inv16_out_o, and_out_o;
	logic        inv16_enable_output_o, inv32_enable_output_o, and_enable_output_o;
	int          n_fail = 0, compares = 0;

	lecl_top i_dut (.*);

	initial forever #25 ref_clk_i = ~ref_clk_i;

	// ==========================================
	// shared tasks
	task automatic chk_bit(input string name, input logic exp, input logic got);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// idle edge after the strobe keeps two strobes from meeting in one step
	task automatic scan_once;
		scan_i = 1'h1;
		@(negedge ref_clk_i);
		scan_i = 1'h0;
		@(negedge ref_clk_i);
	endtask

	task automatic phase_once;
		phase_i = 1'h1;
		@(negedge ref_clk_i);
		phase_i = 1'h0;
		@(negedge ref_clk_i);
	endtask

	task automatic report_and_stop;
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ==========================================
	// scenarios
	task automatic t_result_edges;
		logic [3:0] fin = 4'b0110, fex = 4'b0001, rin = 4'b1011, rex = 4'b1010;
		for (int i = 3; i >= 0; i--)
		begin
			rfall_lr_i = fin[i];
			rrise_lr_i = rin[i];
			scan_once();
			chk_bit("rfall_lr_o", fex[i], rfall_lr_o);
			chk_bit("rrise_lr_o", rex[i], rrise_lr_o);
		end
		rfall_lr_i = 1'h1;
		rrise_lr_i = 1'h0;
		@(negedge ref_clk_i);
		chk_bit("rfall_lr_o", 1'h1, rfall_lr_o);
		chk_bit("rrise_lr_o", 1'h0, rrise_lr_o);
		$display("test result_edges done");
	endtask

	task automatic t_bit_edges;
		logic [8:0] lr = 9'b110111011, bt = 9'b110100101;
		logic [8:0] pe = 9'b100100001, ne = 9'b000010010;
		for (int i = 8; i >= 0; i--)
		begin
			pos_lr_i = lr[i];
			neg_lr_i = lr[i];
			pos_bit_i = bt[i];
			neg_bit_i = bt[i];
			scan_once();
			chk_bit("pos_q_o", pe[i], pos_q_o);
			chk_bit("pos_lr_o", pe[i], pos_lr_o);
			chk_bit("neg_q_o", ne[i], neg_q_o);
			chk_bit("neg_lr_o", ne[i], neg_lr_o);
		end
		$display("test bit_edges done");
	endtask

	task automatic t_compare;
		logic [31:0] fa [6] = '{32'hABCD_FFFE, 32'h1234_0005, 32'h0000_7FFF,
			32'h8000_0000, 32'h0001_0000, 32'hFFFF_FFFF};
		logic [31:0] fb [6] = '{32'h0000_0003, 32'h5678_0005, 32'hFFFF_8000,
			32'h7FFF_FFFF, 32'h0002_0000, 32'hFFFF_FFFF};
		logic signed [31:0] a, b;
		logic e;
		for (int p = 0; p < 6; p++)
			for (int r = 0; r < 8; r++)
			begin
				cmp_wide_i = (p >= 3);
				cmp_rel_i = r[2:0];
				cmp_first_operand_i = fa[p];
				cmp_second_operand_i = fb[p];
				a = cmp_wide_i ? fa[p] : {{16{fa[p][15]}}, fa[p][15:0]};
				b = cmp_wide_i ? fb[p] : {{16{fb[p][15]}}, fb[p][15:0]};
				case (r)
					0: e = (a == b);
					1: e = (a != b);
					2: e = (a > b);
					3: e = (a < b);
					4: e = (a >= b);
					5: e = (a <= b);
					default: e = 1'h0;
				endcase
				scan_once();
				chk_bit("cmp_lr_o", e, cmp_lr_o);
			end
		$display("test compare done");
	endtask

	// scan held high: every cycle is an evaluation
	task automatic t_held_scan;
		logic [3:0] lv = 4'b0110, fe = 4'b1001, re = 4'b0100;
		scan_i = 1'h1;
		for (int i = 3; i >= 0; i--)
		begin
			rfall_lr_i = lv[i];
			rrise_lr_i = lv[i];
			pos_lr_i = 1'h1;
			neg_lr_i = 1'h1;
			pos_bit_i = lv[i];
			neg_bit_i = lv[i];
			@(negedge ref_clk_i);
			chk_bit("rfall_lr_o", fe[i], rfall_lr_o);
			chk_bit("rrise_lr_o", re[i], rrise_lr_o);
			chk_bit("pos_q_o", re[i], pos_q_o);
			chk_bit("neg_q_o", fe[i], neg_q_o);
		end
		scan_i = 1'h0;
		@(negedge ref_clk_i);
		$display("test held_scan done");
	endtask

	task automatic t_enabled;
		{inv16_en_i, inv32_en_i, and_en_i} = 3'h7;
		inv16_in_i = 16'h4181;
		inv32_in_i = 32'hF0FF_FFF0;
		and_first_operand_i = 16'h5555;
		and_second_operand_i = 16'h000F;
		#1;
		chk_word("enable_outputs", 32'h7, {29'h0, inv16_enable_output_o, inv32_enable_output_o,
			and_enable_output_o});
		@(negedge ref_clk_i);
		phase_once();
		chk_word("inv16_out_o", 32'hBE7E, inv16_out_o);
		chk_word("inv32_out_o", 32'h0F00_000F, inv32_out_o);
		chk_word("and_out_o", 32'h0005, and_out_o);
		{inv16_en_i, inv32_en_i, and_en_i} = 3'h0;
		inv16_in_i = 16'h0000;
		inv32_in_i = 32'h0000_0000;
		and_first_operand_i = 16'hFFFF;
		and_second_operand_i = 16'hA5A5;
		#1;
		chk_word("enable_outputs", 32'h0, {29'h0, inv16_enable_output_o, inv32_enable_output_o,
			and_enable_output_o});
		@(negedge ref_clk_i);
		phase_once();
		{inv16_en_i, inv32_en_i, and_en_i} = 3'h7;
		@(negedge ref_clk_i);
		chk_word("inv16_out_o", 32'hBE7E, inv16_out_o);
		chk_word("inv32_out_o", 32'h0F00_000F, inv32_out_o);
		chk_word("and_out_o", 32'h0005, and_out_o);
		phase_once();
		chk_word("inv16_out_o", 32'hFFFF, inv16_out_o);
		chk_word("inv32_out_o", 32'hFFFF_FFFF, inv32_out_o);
		chk_word("and_out_o", 32'hA5A5, and_out_o);
		$display("test enabled done");
	endtask

	// ==========================================
	// main sequence and watchdog
	initial
	begin
		repeat (2) @(negedge ref_clk_i);
		sys_rst_i = 1'h0;
		chk_word("reset_outputs", 32'h0, {inv16_out_o, and_out_o});
		chk_word("reset_outputs", 32'h0, inv32_out_o);
		chk_word("reset_outputs", 32'h0, {25'h0, rfall_lr_o, rrise_lr_o, pos_q_o, pos_lr_o,
			neg_q_o, neg_lr_o, cmp_lr_o});
		t_result_edges();
		t_bit_edges();
		t_compare();
		t_held_scan();
		t_enabled();
		report_and_stop();
	end

	initial
	begin
		repeat (1000) @(posedge ref_clk_i);
		n_fail++;
		report_and_stop();
	end
endmodule // test_ladder_edge_compare_logic
